/* testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, rx_pin, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
    logic awready, wready, arready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] lcs [10] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h66, 8'h66, 8'h62, 8'he6, 8'he2, 8'h68};
    logic [1:0] pss [10] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h0};
    int bad_count, checks_done;

    urxfb_top i_dut
    (
        .clk(clk), .reset(reset), .clk_en(1'b1), .rx_pin(rx_pin), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    urxfb_line_model i_tx
    (
        .clk(clk),
        .line(rx_pin)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------
    // Bus tasks and checks
    // ------------------------------
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask : wr
    task rdr(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask : rdr
    // Polling the status word keeps the wait bounded only by the watchdog.
    task get;
        do rdr(12'h034);
        while (rd[1]);
        rdr(12'h038);
    endtask : get
    task frame(input logic [7:0] lc, input logic [31:0] pc, input int per,
        input logic [7:0] d, input logic pb, input logic st2);
        logic [7:0] m;
        logic pe;
        int n;
        n = 5 + lc[6:5];
        m = 8'hff >> (8 - n);
        pe = lc[1] & (lc[7] ? pb == lc[2] : (^(d & m) ^ pb) == lc[2]);
        wr(12'h01c, {24'h0000_00, lc});
        wr(12'h030, pc);
        i_tx.send(n, d, lc[1], pb, lc[3], st2, per);
        get;
        check("char", rd, {22'h0, lc[3]&~st2, pe, d&m});
    endtask : frame

    initial
    begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = {24'h0000_00, 32'h0000_0000, 4'hf};
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rdr(12'h01c);
        check("line ctrl", rd, 32'h0000_0000);
        rdr(12'h024);
        check("div int", rd, 32'h0000_0000);
        rdr(12'h028);
        check("div frac", rd, 32'h0000_0000);
        wr(12'h024, 32'hffff_ffff);
        rdr(12'h024);
        check("div int", rd, 32'h0000_ffff);
        wr(12'h028, 32'hffff_ffff);
        rdr(12'h028);
        check("div frac", rd, 32'h0000_003f);
        wr(12'h01c, 32'hffff_ffff);
        rdr(12'h01c);
        check("line ctrl", rd, 32'h0000_00fe);
        wr(12'h040, 32'h0000_0001);
        check("bresp", rs, 32'h0000_0002);
        rdr(12'h040);
        check("rresp", rs, 32'h0000_0002);
        wr(12'h024, 32'h0000_0001);
        wr(12'h028, 32'h0000_0000);
        for (int i = 0; i < 10; i++) frame(lcs[i], 1, 16, 8'hb5 ^ i, pss[i][1], pss[i][0]);
        frame(8'h60, 32'h0000_0003, 8, 8'h3c, 1'b0, 1'b1);
        wr(12'h028, 32'h0000_0020);
        frame(8'h60, 32'h0000_0001, 24, 8'hc3, 1'b0, 1'b1);
        wr(12'h028, 32'h0000_0000);
        // A divisor written mid-character must wait for that character to end.
        fork
            i_tx.send(8, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b1, 16);
            begin
                repeat (40) @(posedge clk);
                wr(12'h024, 32'h0000_0002);
            end
        join
        get;
        check("old divisor", rd, 32'h0000_005a);
        frame(8'h60, 32'h0000_0001, 32, 8'ha6, 1'b0, 1'b1);
        wr(12'h01c, 32'h0000_0070);
        i_tx.send(8, 8'h11, 1'b0, 1'b0, 1'b0, 1'b1, 32);
        i_tx.send(8, 8'h22, 1'b0, 1'b0, 1'b0, 1'b1, 32);
        get;
        check("queued 1", rd, 32'h0000_0011);
        get;
        check("queued 2", rd, 32'h0000_0022);
        wr(12'h01c, 32'h0000_0060);
        i_tx.send(8, 8'h33, 1'b0, 1'b0, 1'b0, 1'b1, 32);
        i_tx.send(8, 8'h44, 1'b0, 1'b0, 1'b0, 1'b1, 32);
        get;
        check("single", rd, 32'h0000_0033);
        rdr(12'h034);
        check("status", rd, 32'h0000_0003);
        test_done;
    end

    initial
    begin
        #400us;
        bad_count++;
        test_done;
    end
endmodule : testbench

/* urxfb_defs.svh */
`ifndef URXFB_DEFS_SVH
`define URXFB_DEFS_SVH

// ------------------------------
// Register byte offsets
// ------------------------------
`define URXFB_OFF_LINE_CTRL 12'h01C
`define URXFB_OFF_DIV_INT 12'h024
`define URXFB_OFF_DIV_FRAC 12'h028
`define URXFB_OFF_PORT_CTRL 12'h030
`define URXFB_OFF_RX_STATUS 12'h034
`define URXFB_OFF_RX_DATA 12'h038

// ------------------------------
// Field positions and reset values
// ------------------------------
`define URXFB_LC_PARITY_EN 1
`define URXFB_LC_EVEN_SEL 2
`define URXFB_LC_TWO_STOP 3
`define URXFB_LC_QUEUE_EN 4
`define URXFB_LC_WLEN_LO 5
`define URXFB_LC_STICK 7
`define URXFB_PC_ENABLE 0
`define URXFB_PC_OVS8 1
`define URXFB_LC_RESET 8'h00
`define URXFB_DI_RESET 16'h0000
`define URXFB_DF_RESET 6'h00
`define URXFB_AXI_OKAY 2'b00
`define URXFB_AXI_SLVERR 2'b10

// ------------------------------
// Timing
// ------------------------------
`define URXFB_OVS_SLOW 16
`define URXFB_OVS_FAST 8

`endif

/* urxfb_frame_rx.sv */
`include "urxfb_defs.svh"

module urxfb_frame_rx
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic enable,
    input wire logic rx_line,
    input wire urxfb_pkg::urxfb_cfg_s cfg,
    urxfb_tick_if.user t,
    input wire logic [15:0] div_int,
    input wire logic [5:0] div_frac,
    input wire logic ovs8,
    output logic busy,
    output logic done,
    output logic [7:0] data,
    output logic parity_err,
    output logic frame_err
);
    import urxfb_pkg::*;

    urxfb_state_e state_q;
    logic [3:0] os_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic par_q;
    logic stop2_q;
    logic load_q;
    logic [3:0] os_last;
    logic [3:0] os_mid;
    logic [2:0] last_bit;
    logic at_end;
    logic at_mid;
    logic exp_par;

    assign os_last = ovs8 ? 4'(`URXFB_OVS_FAST - 1) : 4'(`URXFB_OVS_SLOW - 1);
    assign os_mid = ovs8 ? 4'(`URXFB_OVS_FAST / 2 - 1) : 4'(`URXFB_OVS_SLOW / 2 - 1);
    assign last_bit = {1'b1, cfg.word_len};
    assign at_end = t.tick && os_q == os_last;
    assign at_mid = t.tick && os_q == os_mid;
    // Stick parity forces a constant; otherwise even/odd count of ones.
    assign exp_par = cfg.stick ? ~cfg.even_sel : (par_q ^ ~cfg.even_sel);

    // Divisor is sampled only while idle, so it never moves mid-character.
    assign t.div_int = div_int;
    assign t.div_frac = div_frac;
    assign t.ovs8 = ovs8;
    assign t.load = load_q;
    assign busy = state_q != URXFB_IDLE;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= URXFB_IDLE;
            os_q <= 4'h0;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            par_q <= 1'b0;
            stop2_q <= 1'b0;
            load_q <= 1'b1;
            done <= 1'b0;
            data <= 8'h00;
            parity_err <= 1'b0;
            frame_err <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            load_q <= 1'b0;
            if (t.tick && state_q != URXFB_IDLE)
            begin
                os_q <= at_end ? 4'h0 : os_q + 4'h1;
            end
            case (state_q)
                URXFB_IDLE:
                begin
                    load_q <= 1'b1;
                    if (enable && !rx_line)
                    begin
                        state_q <= URXFB_START;
                        os_q <= 4'h0;
                        load_q <= 1'b0;
                    end
                end
                URXFB_START:
                begin
                    if (at_mid && rx_line)
                    begin
                        state_q <= URXFB_IDLE;
                    end
                    else if (at_end)
                    begin
                        state_q <= URXFB_DATA;
                        bit_q <= 3'h0;
                        sh_q <= 8'h00;
                        par_q <= 1'b0;
                    end
                end
                URXFB_DATA:
                begin
                    if (at_mid)
                    begin
                        sh_q[bit_q] <= rx_line;
                        par_q <= par_q ^ rx_line;
                    end
                    if (at_end)
                    begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == last_bit)
                        begin
                            state_q <= cfg.parity_en ? URXFB_PARITY : URXFB_STOP;
                            stop2_q <= 1'b0;
                            parity_err <= 1'b0;
                        end
                    end
                end
                URXFB_PARITY:
                begin
                    if (at_mid)
                    begin
                        parity_err <= rx_line != exp_par;
                    end
                    if (at_end)
                    begin
                        state_q <= URXFB_STOP;
                    end
                end
                URXFB_STOP:
                begin
                    if (at_mid)
                    begin
                        if (!rx_line)
                        begin
                            frame_err <= 1'b1;
                        end
                        else if (!stop2_q)
                        begin
                            frame_err <= 1'b0;
                        end
                        if (!cfg.two_stop || stop2_q)
                        begin
                            state_q <= URXFB_IDLE;
                            done <= 1'b1;
                            data <= sh_q;
                        end
                    end
                    if (at_end)
                    begin
                        stop2_q <= 1'b1;
                    end
                end
                default:
                begin
                    state_q <= URXFB_IDLE;
                end
            endcase
        end
    end
endmodule : urxfb_frame_rx

/* urxfb_line_model.sv */
module urxfb_line_model
(
    input wire logic clk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    // The line idles high between frames, as an asynchronous link does.
    initial line = 1'b1;
    task automatic put(input logic b, input int per);
        @(posedge clk);
        line <= b;
        repeat (per - 1) @(posedge clk);
    endtask : put
    task automatic send(input int n, input logic [7:0] d, input logic pen, input logic pb,
        input logic two, input logic st2, input int per);
        put(1'b0, per);
        for (int i = 0; i < n; i++) put(d[i], per);
        if (pen) put(pb, per);
        put(1'b1, per);
        if (two) put(st2, per);
        @(posedge clk);
        line <= 1'b1;
    endtask : send
endmodule : urxfb_line_model

/* urxfb_pkg.sv */
package urxfb_pkg;

    typedef enum logic [2:0] {
        URXFB_IDLE,
        URXFB_START,
        URXFB_DATA,
        URXFB_PARITY,
        URXFB_STOP
    } urxfb_state_e;

    typedef struct packed {
        logic parity_en;
        logic even_sel;
        logic two_stop;
        logic queue_en;
        logic [1:0] word_len;
        logic stick;
    } urxfb_cfg_s;

endpackage : urxfb_pkg

/* urxfb_tick_gen.sv */
`include "urxfb_defs.svh"

module urxfb_tick_gen
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    urxfb_tick_if.gen t
);
    import urxfb_pkg::*;

    // ------------------------------
    // Fractional divider
    // ------------------------------
    // A 1/64 accumulator stretches one period by a clock on overflow.
    logic [15:0] cnt_q;
    logic [6:0] acc_q;
    logic [6:0] acc_sum;
    logic stretch;
    logic [15:0] period;

    assign acc_sum = {1'b0, acc_q[5:0]} + {1'b0, t.div_frac};
    assign stretch = acc_sum[6];
    assign period = (t.div_int == 16'h0000) ? 16'h0001 : t.div_int;
    assign t.tick = ce && (cnt_q == 16'h0000) && (t.div_int != 16'h0000);

    always_ff @(posedge clk)
    begin
        if (reset || t.load)
        begin
            cnt_q <= 16'h0000;
            acc_q <= 7'h00;
        end
        else if (ce && t.tick)
        begin
            acc_q <= {1'b0, acc_sum[5:0]};
            cnt_q <= stretch ? period : period - 16'h0001;
        end
        else if (ce && cnt_q != 16'h0000)
        begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end
endmodule : urxfb_tick_gen

/* urxfb_tick_if.sv */
interface urxfb_tick_if;
    logic [15:0] div_int;
    logic [5:0] div_frac;
    logic ovs8;
    logic load;
    logic tick;

    modport gen
    (
        input div_int,
        input div_frac,
        input ovs8,
        input load,
        output tick
    );
    modport user
    (
        output div_int,
        output div_frac,
        output ovs8,
        output load,
        input tick
    );
endinterface : urxfb_tick_if

/* urxfb_top.sv */
// Notes on behaviour
// - With parity enabled a parity bit follows the data and is checked; otherwise none.
// - Parity checks for an even count of ones when even select is 1, odd when 0.
// - Stick parity checks a constant bit: 0 for even select, 1 for odd select.
// - One stop bit is checked, or two when the two-stop select is set.
// - With the queue enabled characters are queued, otherwise one holding slot is used.
// - Word length 00b..11b selects five to eight data bits.
// - With oversampling select 0 each bit spans sixteen divisor periods.
// - With oversampling select 1 each bit spans eight divisor periods.
// - The divisor is a 16-bit integer and a 6-bit fraction in separate registers.
// - A new divisor takes effect only once the current character has completed.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "urxfb_defs.svh"

module urxfb_top
#(
    parameter int QUEUE_DEPTH = 16
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic rx_pin,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import urxfb_pkg::*;

    localparam int QW = $clog2(QUEUE_DEPTH);

    // ------------------------------
    // Pin synchroniser
    // ------------------------------
    // A change is accepted once stages two and three agree.
    logic [2:0] sync_q;
    logic rx_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync_q <= 3'b111;
            rx_q <= 1'b1;
        end
        else if (clk_en)
        begin
            sync_q <= {sync_q[1:0], rx_pin};
            if (sync_q[1] == sync_q[2])
            begin
                rx_q <= sync_q[2];
            end
        end
    end

    // ------------------------------
    // Registers
    // ------------------------------
    logic [7:0] line_ctrl_q;
    logic [15:0] div_int_q;
    logic [5:0] div_frac_q;
    logic enable_q;
    logic ovs8_q;
    urxfb_cfg_s cfg;

    assign cfg.parity_en = line_ctrl_q[`URXFB_LC_PARITY_EN];
    assign cfg.even_sel = line_ctrl_q[`URXFB_LC_EVEN_SEL];
    assign cfg.two_stop = line_ctrl_q[`URXFB_LC_TWO_STOP];
    assign cfg.queue_en = line_ctrl_q[`URXFB_LC_QUEUE_EN];
    assign cfg.word_len = line_ctrl_q[`URXFB_LC_WLEN_LO +: 2];
    assign cfg.stick = line_ctrl_q[`URXFB_LC_STICK];

    // ------------------------------
    // Write channel
    // ------------------------------
    // Address and data are latched independently so either may come first.
    logic aw_full_q;
    logic w_full_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic wr_lc;
    logic wr_di;
    logic wr_df;
    logic wr_pc;
    logic wr_ok;

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid && clk_en;
    assign wr_lc = aw_addr_q == `URXFB_OFF_LINE_CTRL;
    assign wr_di = aw_addr_q == `URXFB_OFF_DIV_INT;
    assign wr_df = aw_addr_q == `URXFB_OFF_DIV_FRAC;
    assign wr_pc = aw_addr_q == `URXFB_OFF_PORT_CTRL;
    assign wr_ok = wr_lc || wr_di || wr_df || wr_pc
        || aw_addr_q == `URXFB_OFF_RX_STATUS || aw_addr_q == `URXFB_OFF_RX_DATA;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `URXFB_AXI_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `URXFB_AXI_OKAY : `URXFB_AXI_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            line_ctrl_q <= `URXFB_LC_RESET;
            div_int_q <= `URXFB_DI_RESET;
            div_frac_q <= `URXFB_DF_RESET;
            enable_q <= 1'b0;
            ovs8_q <= 1'b0;
        end
        else if (do_write)
        begin
            if (wr_lc && w_strb_q[0])
            begin
                line_ctrl_q <= {w_data_q[7:1], 1'b0};
            end
            if (wr_di)
            begin
                if (w_strb_q[0])
                begin
                    div_int_q[7:0] <= w_data_q[7:0];
                end
                if (w_strb_q[1])
                begin
                    div_int_q[15:8] <= w_data_q[15:8];
                end
            end
            if (wr_df && w_strb_q[0])
            begin
                div_frac_q <= w_data_q[5:0];
            end
            if (wr_pc && w_strb_q[0])
            begin
                enable_q <= w_data_q[`URXFB_PC_ENABLE];
                ovs8_q <= w_data_q[`URXFB_PC_OVS8];
            end
        end
    end

    // ------------------------------
    // Divisor in use
    // ------------------------------
    // Software copies move to the active set only between characters.
    logic [15:0] act_int_q;
    logic [5:0] act_frac_q;
    logic act_ovs8_q;
    logic rx_busy;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            act_int_q <= `URXFB_DI_RESET;
            act_frac_q <= `URXFB_DF_RESET;
            act_ovs8_q <= 1'b0;
        end
        else if (clk_en && !rx_busy)
        begin
            act_int_q <= div_int_q;
            act_frac_q <= div_frac_q;
            act_ovs8_q <= ovs8_q;
        end
    end

    urxfb_tick_if tick_bus();

    urxfb_tick_gen u_tick
    (
        .clk(clk),
        .reset(reset),
        .ce(clk_en),
        .t(tick_bus.gen)
    );

    logic rx_done;
    logic [7:0] rx_data;
    logic rx_perr;
    logic rx_ferr;

    urxfb_frame_rx u_frame
    (
        .clk(clk),
        .reset(reset),
        .ce(clk_en),
        .enable(enable_q),
        .rx_line(rx_q),
        .cfg(cfg),
        .t(tick_bus.user),
        .div_int(act_int_q),
        .div_frac(act_frac_q),
        .ovs8(act_ovs8_q),
        .busy(rx_busy),
        .done(rx_done),
        .data(rx_data),
        .parity_err(rx_perr),
        .frame_err(rx_ferr)
    );

    // ------------------------------
    // Receive queue
    // ------------------------------
    // In single-character mode the depth collapses to one entry.
    logic [9:0] mem_q [QUEUE_DEPTH];
    logic [QW-1:0] wp_q;
    logic [QW-1:0] rp_q;
    logic [QW:0] cnt_q;
    logic [QW:0] cap;
    logic q_empty;
    logic q_full;
    logic q_push;
    logic q_pop;
    logic rd_data_sel;
    logic overrun_q;

    assign cap = cfg.queue_en ? (QW + 1)'(QUEUE_DEPTH) : (QW + 1)'(1);
    assign q_empty = cnt_q == '0;
    assign q_full = cnt_q >= cap;
    assign q_push = clk_en && rx_done && !q_full;
    assign q_pop = clk_en && s_axi_arvalid && s_axi_arready && rd_data_sel && !q_empty;

    always_ff @(posedge clk)
    begin
        if (q_push)
        begin
            mem_q[wp_q] <= {rx_ferr, rx_perr, rx_data};
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            overrun_q <= 1'b0;
        end
        else if (clk_en)
        begin
            wp_q <= q_push ? wp_q + QW'(1) : wp_q;
            rp_q <= q_pop ? rp_q + QW'(1) : rp_q;
            cnt_q <= cnt_q + (QW + 1)'(q_push) - (QW + 1)'(q_pop);
            if (rx_done && q_full)
            begin
                overrun_q <= 1'b1;
            end
            else if (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h00D)
            begin
                overrun_q <= 1'b0;
            end
        end
    end

    // ------------------------------
    // Read channel
    // ------------------------------
    logic [11:0] ra;
    logic [31:0] rd_mux;
    logic rd_ok;

    assign ra = {s_axi_araddr[11:2], 2'b00};
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_data_sel = ra == `URXFB_OFF_RX_DATA;
    assign rd_ok = ra == `URXFB_OFF_LINE_CTRL || ra == `URXFB_OFF_DIV_INT
        || ra == `URXFB_OFF_DIV_FRAC || ra == `URXFB_OFF_PORT_CTRL
        || ra == `URXFB_OFF_RX_STATUS || rd_data_sel;
    assign rd_mux = ra == `URXFB_OFF_LINE_CTRL ? {24'h00_0000, line_ctrl_q}
        : ra == `URXFB_OFF_DIV_INT ? {16'h0000, div_int_q}
        : ra == `URXFB_OFF_DIV_FRAC ? {26'h000_0000, div_frac_q}
        : ra == `URXFB_OFF_PORT_CTRL ? {30'h0000_0000, ovs8_q, enable_q}
        : ra == `URXFB_OFF_RX_STATUS ? {27'h000_0000, overrun_q, rx_busy, q_full, q_empty,
            rx_q}
        : (rd_data_sel && !q_empty) ? {22'h00_0000, mem_q[rp_q]}
        : 32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `URXFB_AXI_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `URXFB_AXI_OKAY : `URXFB_AXI_SLVERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : urxfb_top

/* urxfb_top_assertions.sv */
`include "urxfb_defs.svh"

module urxfb_axi_chk
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic ar_mapped;
    assign ar_mapped = {s_axi_araddr[11:2], 2'b00} inside {`URXFB_OFF_LINE_CTRL,
        `URXFB_OFF_DIV_INT, `URXFB_OFF_DIV_FRAC, `URXFB_OFF_PORT_CTRL,
        `URXFB_OFF_RX_STATUS, `URXFB_OFF_RX_DATA};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready && clk_en;
    endsequence
    property p_b_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
    a_b_answer: assert property (p_b_answer) else $error("write not answered");
    property p_r_answer; s_rd_taken |=> s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read not answered");
    property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken during response");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken during response");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    property p_r_slverr; s_rd_taken ##0 !ar_mapped |=> s_axi_rresp == `URXFB_AXI_SLVERR;
    endproperty
    a_r_slverr: assert property (p_r_slverr) else $error("unmapped read not refused");
    property p_r_okay; s_rd_taken ##0 ar_mapped |=> s_axi_rresp == `URXFB_AXI_OKAY; endproperty
    a_r_okay: assert property (p_r_okay) else $error("mapped read refused");
    property p_int_width;
        s_rd_taken ##0 s_axi_araddr == `URXFB_OFF_DIV_INT |=> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_int_width: assert property (p_int_width) else $error("integer divisor too wide");
    property p_frac_width;
        s_rd_taken ##0 s_axi_araddr == `URXFB_OFF_DIV_FRAC |=> s_axi_rdata[31:6] == 26'h0;
    endproperty
    a_frac_width: assert property (p_frac_width) else $error("fraction too wide");
endmodule : urxfb_axi_chk

bind urxfb_top urxfb_axi_chk i_axi_chk
(
    .clk(clk), .reset(reset), .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
